// ===== core/pbg_port.sv
// pbg_port: eight-pin bidirectional port with pull-ups, change detection
// on the upper four pins, segment and debug overrides.
// assumes pins arrive asynchronously, segment and debug drives come from
// logic on core_clk, and software uses the plain register port.
`timescale 1ns/1ps

module pbg_port #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_wr_move,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output logic [7:0] pin_pullup,
  // segment driver
  input wire logic [5:0] segment_drive,
  output logic [5:0] segment_active,
  // programming and debug interface
  input wire logic prog_enable,
  input wire logic prog_data_out,
  input wire logic prog_data_drive,
  output logic prog_clock_in,
  output logic prog_data_in,
  // to neighbouring units
  output logic [3:0] ext_irq_in,
  output logic charge_meas_edge_1,
  output logic charge_meas_edge_2,
  output logic change_irq_high,
  output logic change_irq_low,
  output logic change_wake
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (SYNC_STAGES != 2) begin : g_bad_sync
    $error("pbg_port: SYNC_STAGES must be 2");
  end
  // the logic below is written for one fixed pin arrangement; refuse others
  if (pbg_pkg::PORT_WIDTH != 8) begin : g_bad_width
    $error("pbg_port: port must be eight pins wide");
  end
  if (pbg_pkg::SEG_PINS != 6) begin : g_bad_seg_pins
    $error("pbg_port: segment map covers exactly six pins");
  end
  if (pbg_pkg::EXT_IRQ_PINS != 4) begin : g_bad_ext_pins
    $error("pbg_port: four external request pins expected");
  end
  if (pbg_pkg::CHANGE_MSB - pbg_pkg::CHANGE_LSB != 3) begin : g_bad_change_span
    $error("pbg_port: change compare spans four pins");
  end
  if (pbg_pkg::CHANGE_MSB >= pbg_pkg::PORT_WIDTH) begin : g_bad_change_msb
    $error("pbg_port: change compare beyond the port");
  end
  if (pbg_pkg::PIN_PROG_DATA >= pbg_pkg::PORT_WIDTH) begin : g_bad_prog_data
    $error("pbg_port: debug data pin beyond the port");
  end
  if (pbg_pkg::PIN_PROG_CLOCK >= pbg_pkg::PORT_WIDTH) begin : g_bad_prog_clock
    $error("pbg_port: debug clock pin beyond the port");
  end
  if (pbg_pkg::PIN_EDGE_2 >= pbg_pkg::SEG_PINS) begin : g_bad_edge_pin
    $error("pbg_port: edge inputs must sit on segment-capable pins");
  end
  if (pbg_pkg::PIN_PROG_CLOCK < pbg_pkg::SEG_PINS) begin : g_bad_prog_overlap
    $error("pbg_port: debug pins must not share a segment pin");
  end

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  // offset 0 pin_level_b: read gives synced pins, write lands in latch
  // offset 1 output_latch_b: plain latch, read back as written
  // offset 2 direction_b: 1 = input, 0 = driven from the latch
  // offset 3 int_control_main: bit 0 change_flag, bit 3 change_irq_enable
  // offset 4 int_control_edge_priority: bit 7 pullup_enable_n,
  //          bit 0 change_irq_priority
  // offset 5 int_control_external: plain storage for the neighbours
  // offset 6 segment_enable_low: bits 3..0 own pins 4..1
  // offset 7 segment_enable_upper: bit 6 owns pin 0, bit 5 owns pin 5
  // bits without a function here are plain storage for other units.
  //
  // pin priority, highest first: segment, debug interface, port.
  // a segment pin is analog, so its inputs toward the neighbouring units read as low.
  // while the debug interface owns them, the debug clock pin is never driven; only the data pin may be.
  //
  // limitation: a read of pin_level_b moves the change reference, so
  // software that polls the port can miss a change between two reads.
  // trade-off: the flag set is stretched one cycle after the mismatch ends,
  // which costs one flop but makes a too-early clear lose reliably.

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // address match, used by every write decode and the port-access check
  function automatic logic pbg_hit(input logic [2:0] addr, input logic [2:0] off);
    pbg_hit = (addr == off);
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] output_latch_b;
  logic [7:0] direction_b;
  logic [7:0] int_control_main;
  logic [7:0] int_control_edge_priority;
  logic [7:0] int_control_external;
  logic [7:0] segment_enable_low;
  logic [7:0] segment_enable_upper;
  logic [3:0] change_ref;
  logic mismatch_d;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] next_output_latch_b;
  logic [7:0] next_direction_b;
  logic [7:0] next_int_control_main;
  logic [7:0] next_int_control_edge_priority;
  logic [7:0] next_int_control_external;
  logic [7:0] next_segment_enable_low;
  logic [7:0] next_segment_enable_upper;
  logic [3:0] next_change_ref;
  logic next_mismatch_d;
  logic [7:0] next_reg_rdata;

  logic [5:0] seg_en;
  logic [7:0] seg_mask;
  logic [7:0] prog_mask;
  logic port_access;
  logic [3:0] pin_mismatch;
  logic mismatch;
  logic flag_set;
  logic pullup_enable_n;

  // ------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------
  // only the second stage is read; first stage may be metastable
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // ------------------------------------------------------------
  // pin function overrides
  // ------------------------------------------------------------
  // segment enables gathered per pin from the two scattered registers
  always_comb begin
    seg_en = {segment_enable_upper[pbg_pkg::SEG_PIN5_UPPER_BIT],
              segment_enable_low[3:0],
              segment_enable_upper[pbg_pkg::SEG_PIN0_UPPER_BIT]};
    seg_mask = {2'b00, seg_en};
    prog_mask = '0;
    prog_mask[pbg_pkg::PIN_PROG_CLOCK] = prog_enable;
    prog_mask[pbg_pkg::PIN_PROG_DATA] = prog_enable;
    pullup_enable_n = int_control_edge_priority[pbg_pkg::BIT_PULLUP_ENABLE_N];
  end

  // per-pin output mux: segment first, then debug, then the port latch
  for (genvar i = 0; i < pbg_pkg::PORT_WIDTH; i++) begin : g_pin
    always_comb begin
      if (seg_mask[i]) begin
        pin_out[i] = segment_drive[i % pbg_pkg::SEG_PINS];
        pin_oe_n[i] = 1'b0;
      end else if (prog_mask[i]) begin
        // clock pin is input only; data pin follows the debug engine
        pin_out[i] = (i == pbg_pkg::PIN_PROG_DATA) ? prog_data_out : 1'b0;
        pin_oe_n[i] = !((i == pbg_pkg::PIN_PROG_DATA) && prog_data_drive);
      end else begin
        pin_out[i] = output_latch_b[i];
        pin_oe_n[i] = direction_b[i];
      end
      // pull-up only on a released input pin under the shared enable
      pin_pullup[i] = !pullup_enable_n && pin_oe_n[i] && !seg_mask[i];
    end
  end

  assign segment_active = seg_en;

  // ------------------------------------------------------------
  // inputs toward neighbouring units
  // ------------------------------------------------------------
  // segment pins are analog, so every input below is blocked there; the pin read and change compare still see them
  always_comb begin
    prog_clock_in = prog_enable && pin_sync[pbg_pkg::PIN_PROG_CLOCK];
    prog_data_in = prog_enable && pin_sync[pbg_pkg::PIN_PROG_DATA];
    ext_irq_in = pin_sync[3:0] & direction_b[3:0] & ~seg_en[3:0];
    charge_meas_edge_1 = pin_sync[pbg_pkg::PIN_EDGE_1]
                         && !seg_en[pbg_pkg::PIN_EDGE_1];
    charge_meas_edge_2 = pin_sync[pbg_pkg::PIN_EDGE_2]
                         && !seg_en[pbg_pkg::PIN_EDGE_2];
  end

  // ------------------------------------------------------------
  // change detection
  // ------------------------------------------------------------
  // outputs on the upper pins are masked out of the compare
  always_comb begin
    pin_mismatch = (pin_sync[pbg_pkg::CHANGE_MSB:pbg_pkg::CHANGE_LSB] ^ change_ref)
                   & direction_b[pbg_pkg::CHANGE_MSB:pbg_pkg::CHANGE_LSB];
    mismatch = |pin_mismatch;
    // a move write does not count as a port access
    port_access = pbg_hit(reg_addr, pbg_pkg::OFF_PIN_LEVEL_B)
                  && (reg_rd || (reg_wr && !reg_wr_move));
    next_change_ref = port_access
                      ? pin_sync[pbg_pkg::CHANGE_MSB:pbg_pkg::CHANGE_LSB]
                      : change_ref;
    next_mismatch_d = mismatch;
    // set held one extra cycle so a clear right after the read still loses
    flag_set = mismatch || mismatch_d;
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_comb begin
    next_output_latch_b = output_latch_b;
    next_direction_b = direction_b;
    next_int_control_main = int_control_main;
    next_int_control_edge_priority = int_control_edge_priority;
    next_int_control_external = int_control_external;
    next_segment_enable_low = segment_enable_low;
    next_segment_enable_upper = segment_enable_upper;
    if (reg_wr) begin
      // writing the pin register lands in the output latch
      if (pbg_hit(reg_addr, pbg_pkg::OFF_PIN_LEVEL_B) ||
          pbg_hit(reg_addr, pbg_pkg::OFF_OUTPUT_LATCH_B)) begin
        next_output_latch_b = reg_wdata;
      end
      if (pbg_hit(reg_addr, pbg_pkg::OFF_DIRECTION_B)) begin
        next_direction_b = reg_wdata;
      end
      if (pbg_hit(reg_addr, pbg_pkg::OFF_INT_CONTROL_MAIN)) begin
        next_int_control_main = reg_wdata;
      end
      if (pbg_hit(reg_addr, pbg_pkg::OFF_INT_CONTROL_EDGE_PRIORITY)) begin
        next_int_control_edge_priority = reg_wdata;
      end
      if (pbg_hit(reg_addr, pbg_pkg::OFF_INT_CONTROL_EXTERNAL)) begin
        next_int_control_external = reg_wdata;
      end
      if (pbg_hit(reg_addr, pbg_pkg::OFF_SEGMENT_ENABLE_LOW)) begin
        next_segment_enable_low = reg_wdata;
      end
      if (pbg_hit(reg_addr, pbg_pkg::OFF_SEGMENT_ENABLE_UPPER)) begin
        next_segment_enable_upper = reg_wdata;
      end
    end
    // hardware set wins over a software clear in the same cycle
    if (flag_set) begin
      next_int_control_main[pbg_pkg::BIT_CHANGE_FLAG] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  // data stand in the cycle after the strobe only
  always_comb begin
    next_reg_rdata = pbg_pkg::READ_UNMAPPED;
    if (reg_rd) begin
      case (reg_addr)
        pbg_pkg::OFF_PIN_LEVEL_B: next_reg_rdata = pin_sync;
        pbg_pkg::OFF_OUTPUT_LATCH_B: next_reg_rdata = output_latch_b;
        pbg_pkg::OFF_DIRECTION_B: next_reg_rdata = direction_b;
        pbg_pkg::OFF_INT_CONTROL_MAIN: next_reg_rdata = int_control_main;
        pbg_pkg::OFF_INT_CONTROL_EDGE_PRIORITY: next_reg_rdata = int_control_edge_priority;
        pbg_pkg::OFF_INT_CONTROL_EXTERNAL: next_reg_rdata = int_control_external;
        pbg_pkg::OFF_SEGMENT_ENABLE_LOW: next_reg_rdata = segment_enable_low;
        pbg_pkg::OFF_SEGMENT_ENABLE_UPPER: next_reg_rdata = segment_enable_upper;
        default: next_reg_rdata = pbg_pkg::READ_UNMAPPED;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      output_latch_b <= pbg_pkg::RST_LATCH;
      direction_b <= pbg_pkg::RST_DIRECTION;
      int_control_main <= pbg_pkg::RST_INT_CONTROL_MAIN;
      int_control_edge_priority <= pbg_pkg::RST_INT_CONTROL_EDGE_PRIORITY;
      int_control_external <= pbg_pkg::RST_INT_CONTROL_EXTERNAL;
      segment_enable_low <= pbg_pkg::RST_SEGMENT_ENABLE;
      segment_enable_upper <= pbg_pkg::RST_SEGMENT_ENABLE;
      change_ref <= 4'h0;
      mismatch_d <= 1'b0;
      reg_rdata <= pbg_pkg::READ_UNMAPPED;
    end else begin
      output_latch_b <= next_output_latch_b;
      direction_b <= next_direction_b;
      int_control_main <= next_int_control_main;
      int_control_edge_priority <= next_int_control_edge_priority;
      int_control_external <= next_int_control_external;
      segment_enable_low <= next_segment_enable_low;
      segment_enable_upper <= next_segment_enable_upper;
      change_ref <= next_change_ref;
      mismatch_d <= next_mismatch_d;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ------------------------------------------------------------
  // interrupt request and wake
  // ------------------------------------------------------------
  // request routed to one of two priority lines; wake follows request
  always_comb begin
    change_wake = int_control_main[pbg_pkg::BIT_CHANGE_FLAG]
                  && int_control_main[pbg_pkg::BIT_CHANGE_IRQ_ENABLE];
    change_irq_high = change_wake
                      && int_control_edge_priority[pbg_pkg::BIT_CHANGE_IRQ_PRIORITY];
    change_irq_low = change_wake
                     && !int_control_edge_priority[pbg_pkg::BIT_CHANGE_IRQ_PRIORITY];
  end

endmodule // pbg_port

// ===== core/pbg_pkg.sv
// pbg_pkg: register offsets, bit positions and reset values of the
// eight-pin port with change detection.
// assumes a plain register port with a 3-bit word offset and 8-bit data.
package pbg_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [2:0] OFF_PIN_LEVEL_B = 3'h0;
  localparam logic [2:0] OFF_OUTPUT_LATCH_B = 3'h1;
  localparam logic [2:0] OFF_DIRECTION_B = 3'h2;
  localparam logic [2:0] OFF_INT_CONTROL_MAIN = 3'h3;
  localparam logic [2:0] OFF_INT_CONTROL_EDGE_PRIORITY = 3'h4;
  localparam logic [2:0] OFF_INT_CONTROL_EXTERNAL = 3'h5;
  localparam logic [2:0] OFF_SEGMENT_ENABLE_LOW = 3'h6;
  localparam logic [2:0] OFF_SEGMENT_ENABLE_UPPER = 3'h7;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_CHANGE_FLAG = 0;         // int_control_main
  localparam int BIT_CHANGE_IRQ_ENABLE = 3;   // int_control_main
  localparam int BIT_PULLUP_ENABLE_N = 7;     // int_control_edge_priority
  localparam int BIT_CHANGE_IRQ_PRIORITY = 0; // int_control_edge_priority
  localparam int CHANGE_LSB = 4;              // upper four pins compare
  localparam int CHANGE_MSB = 7;
  localparam int PIN_PROG_CLOCK = 6;
  localparam int PIN_PROG_DATA = 7;
  localparam int PIN_EDGE_1 = 2;
  localparam int PIN_EDGE_2 = 3;
  // segment enable bit for pins 0..5: pin0 upper[6], pin1..4 low[0..3],
  // pin5 upper[5]
  localparam int SEG_PIN0_UPPER_BIT = 6;
  localparam int SEG_PIN5_UPPER_BIT = 5;

  // ------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------
  localparam int PORT_WIDTH = 8;
  localparam int SEG_PINS = 6;
  localparam int EXT_IRQ_PINS = 4;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hFF;        // all inputs
  localparam logic [7:0] RST_INT_CONTROL_MAIN = 8'h00;
  localparam logic [7:0] RST_INT_CONTROL_EDGE_PRIORITY = 8'h80; // pull-ups off
  localparam logic [7:0] RST_INT_CONTROL_EXTERNAL = 8'h00;
  localparam logic [7:0] RST_SEGMENT_ENABLE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

endpackage

// ===== bench/pbg_port_monitor.sv
// pbg_port_monitor: port-level relations of the eight-pin port.
// assumes only pbg_port ports are visible; bound after endmodule.
`timescale 1ns/1ps
module pbg_port_monitor #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pin_pullup,
  input wire logic [5:0] segment_drive,
  input wire logic [5:0] segment_active,
  input wire logic [3:0] ext_irq_in,
  input wire logic charge_meas_edge_1,
  input wire logic change_irq_high,
  input wire logic change_irq_low,
  input wire logic change_wake
);
  logic [7:0] edge_shadow;
  logic [7:0] dir_shadow;
  logic [7:0] next_edge_shadow;
  logic [7:0] next_dir_shadow;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // shadow copies, since the relations hinge on register contents
  always_comb begin
    next_edge_shadow = edge_shadow;
    next_dir_shadow = dir_shadow;
    if (reg_wr && reg_addr == pbg_pkg::OFF_INT_CONTROL_EDGE_PRIORITY) begin
      next_edge_shadow = reg_wdata;
    end
    if (reg_wr && reg_addr == pbg_pkg::OFF_DIRECTION_B) begin
      next_dir_shadow = reg_wdata;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      edge_shadow <= pbg_pkg::RST_INT_CONTROL_EDGE_PRIORITY;
      dir_shadow <= pbg_pkg::RST_DIRECTION;
    end else begin
      edge_shadow <= next_edge_shadow;
      dir_shadow <= next_dir_shadow;
    end
  end

  a_pullup_off_output: assert property ((pin_pullup & ~pin_oe_n) == 8'h00)
    else $error("pull-up on a driven pin");
  a_pullup_needs_enable: assert property (pin_pullup != 8'h00 |-> !edge_shadow[7])
    else $error("pull-up on while shared enable is off");
  a_dir_sets_drive: assert property (((pin_oe_n[5:0] ^ dir_shadow[5:0]) & ~segment_active) == 0)
    else $error("pin drive does not follow direction");
  a_segment_owns_pin: assert property ((pin_oe_n[5:0] & segment_active) == 6'h00 && ((pin_out[5:0] ^ segment_drive) & segment_active) == 6'h00)
    else $error("segment pin not driven by segment");
  a_edge_input_sync: assert property ($past(resetn) && $past(resetn, 2) && !segment_active[2] |-> charge_meas_edge_1 == $past(pin_in[2], 2))
    else $error("edge input not two cycles behind pin");
  a_ext_irq_gated: assert property ((ext_irq_in & ~($past(pin_in[3:0], 2) & pin_oe_n[3:0])) == 4'h0)
    else $error("external request from output or low pin");
  a_irq_high_prio: assert property (change_irq_high |-> edge_shadow[0] && change_wake)
    else $error("high request without priority bit");
  a_irq_low_prio: assert property (change_irq_low |-> !edge_shadow[0] && change_wake)
    else $error("low request with priority bit");
  a_wake_has_irq: assert property (change_wake |-> change_irq_high || change_irq_low)
    else $error("wake without request");
  a_flag_sticky: assert property (change_wake && !(reg_wr && reg_addr == pbg_pkg::OFF_INT_CONTROL_MAIN) |=> change_wake)
    else $error("change request dropped without a write");
endmodule // pbg_port_monitor

bind pbg_port pbg_port_monitor #(.SYNC_STAGES(SYNC_STAGES)) i_pbg_port_monitor (.core_clk, .resetn,
  .reg_addr, .reg_wdata, .reg_wr, .pin_in, .pin_out, .pin_oe_n, .pin_pullup, .segment_drive,
  .segment_active, .ext_irq_in, .charge_meas_edge_1, .change_irq_high, .change_irq_low,
  .change_wake);

// ===== bench/pbg_keys.sv
// pbg_keys: keys and switches hanging on the eight port pins.
// assumes the bench chooses which keys press and at what level.
`timescale 1ns/1ps
module pbg_keys (
  input wire logic core_clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] key_level,
  input wire logic [7:0] key_on,
  output logic [7:0] pin_in
);
  logic wander = 1'b0;
  // a floating pin must never look settled
  always @(posedge core_clk) wander <= ~wander;
  // device drive wins, then a pressed key, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (key_on[i]) pin_in[i] = key_level[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else pin_in[i] = wander ^ i[0];
    end
  end
endmodule // pbg_keys

// ===== bench/pbg_port_tb.sv
// pbg_port_tb: random and corner tests of the port through its registers.
// assumes pbg_pkg, pbg_port, pbg_keys and the bound monitor compiled first.
`timescale 1ns/1ps
module pbg_port_tb;
  logic core_clk, resetn, reg_wr, reg_wr_move, reg_rd, prog_enable;
  logic prog_data_out, prog_data_drive, prog_clock_in, prog_data_in;
  logic charge_meas_edge_1, charge_meas_edge_2, change_irq_high, change_irq_low, change_wake;
  logic [2:0] reg_addr;
  logic [3:0] ext_irq_in;
  logic [5:0] segment_drive, segment_active, sd;
  logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe_n, pin_pullup;
  logic [7:0] key_level, key_on, v, e, lat, dir, keys;
  int err_total = 0;
  int checks_done = 0;

  pbg_port i_pbg_port (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_wr_move,
    .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe_n, .pin_pullup, .segment_drive,
    .segment_active, .prog_enable, .prog_data_out, .prog_data_drive, .prog_clock_in,
    .prog_data_in, .ext_irq_in, .charge_meas_edge_1, .charge_meas_edge_2, .change_irq_high,
    .change_irq_low, .change_wake);
  pbg_keys i_pbg_keys (.core_clk, .pin_out, .pin_oe_n, .pin_pullup, .key_level, .key_on, .pin_in);

  task automatic close_out();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic mv);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_wr_move <= mv;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wr_move <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  // ends between edges so outputs are settled when looked at
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  function automatic logic [7:0] port_exp(input logic [7:0] l, input logic [7:0] d,
                                          input logic [7:0] k);
    return (l & ~d) | (k & d);
  endfunction
  function automatic logic [7:0] rst_exp(input logic [2:0] a);
    case (a)
      3'h1: return pbg_pkg::RST_LATCH;
      3'h2: return pbg_pkg::RST_DIRECTION;
      3'h3: return pbg_pkg::RST_INT_CONTROL_MAIN;
      3'h4: return pbg_pkg::RST_INT_CONTROL_EDGE_PRIORITY;
      3'h5: return pbg_pkg::RST_INT_CONTROL_EXTERNAL;
      default: return pbg_pkg::RST_SEGMENT_ENABLE;
    endcase
  endfunction

  // clock at 40 MHz
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    close_out();
  end
  // main sequence
  initial begin
    {resetn, reg_wr, reg_wr_move, reg_rd, prog_enable, prog_data_out, prog_data_drive} = 7'h00;
    {reg_addr, reg_wdata, segment_drive, key_level} = 25'h000_0000;
    key_on = 8'hFF;
    void'($urandom(3));
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    for (int a = 1; a < 8; a++) begin
      rd(a[2:0], v);
      chk(v, rst_exp(a[2:0]));
    end
    chk(pin_pullup, 8'h00);
    for (int i = 0; i < 12; i++) begin
      lat = 8'($urandom);
      dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      keys = 8'($urandom);
      wr(3'h1, lat, 1'b0);
      wr(3'h2, dir, 1'b0);
      key_level <= keys;
      tick(3);
      rd(3'h0, v);
      e = port_exp(lat, dir, keys);
      chk(v, e);
      chk(pin_oe_n, dir);
      chk({4'h0, ext_irq_in}, {4'h0, e[3:0] & dir[3:0]});
      chk({6'h0, charge_meas_edge_2, charge_meas_edge_1}, {6'h0, e[3:2]});
    end
    // keys released: inputs must float up through the shared pull-up
    key_on <= 8'h00;
    wr(3'h4, 8'h00, 1'b0);
    wr(3'h2, 8'h0F, 1'b0);
    tick(3);
    chk(pin_pullup, 8'h0F);
    rd(3'h0, v);
    chk(v, port_exp(lat, 8'h0F, 8'hFF));
    // change detection: reference taken, then flag cleared three cycles later
    wr(3'h2, 8'hFF, 1'b0);
    key_on <= 8'hFF;
    key_level <= 8'h00;
    tick(3);
    rd(3'h0, v); // one read only, no polling while detection runs
    tick(1);
    wr(3'h3, 8'h08, 1'b0);
    key_level <= 8'h0F;
    tick(4);
    chk({7'h0, change_wake}, 8'h00);
    wr(3'h1, 8'h10, 1'b0);
    wr(3'h2, 8'hEF, 1'b0);
    tick(4);
    chk({7'h0, change_wake}, 8'h00);
    key_level <= 8'h2F;
    tick(4);
    chk({6'h0, change_irq_high, change_irq_low}, 8'h01);
    wr(3'h0, 8'h10, 1'b1);
    tick(1);
    wr(3'h3, 8'h08, 1'b0);
    tick(2);
    chk({7'h0, change_wake}, 8'h01);
    // clear in the very cycle after the read is lost
    @(posedge core_clk);
    reg_addr <= 3'h0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= 3'h3;
    reg_wdata <= 8'h08;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    tick(2);
    chk({7'h0, change_wake}, 8'h01);
    wr(3'h3, 8'h08, 1'b0);
    tick(1);
    chk({7'h0, change_wake}, 8'h00);
    key_level <= 8'h0F;
    tick(4);
    wr(3'h0, 8'h10, 1'b0);
    tick(1);
    wr(3'h3, 8'h08, 1'b0);
    tick(1);
    chk({7'h0, change_wake}, 8'h00);
    wr(3'h4, 8'h01, 1'b0);
    key_level <= 8'h8F;
    tick(4);
    chk({6'h0, change_irq_high, change_irq_low}, 8'h02);
    wr(3'h3, 8'h00, 1'b0);
    tick(1);
    chk({7'h0, change_wake}, 8'h00);
    // segments take the lower six pins whatever the direction says
    sd = 6'($urandom);
    segment_drive <= sd;
    wr(3'h6, 8'h0F, 1'b0);
    wr(3'h7, 8'h60, 1'b0);
    tick(3);
    chk({2'h0, segment_active}, 8'h3F);
    chk({2'h0, pin_out[5:0]}, {2'h0, sd});
    chk({pin_oe_n[5:0], ext_irq_in[1:0]}, 8'h00);
    // debug interface owns the top two pins
    prog_enable <= 1'b1;
    prog_data_drive <= 1'b1;
    prog_data_out <= 1'b1;
    key_level <= 8'h4F;
    tick(3);
    chk({4'h0, pin_oe_n[7], pin_out[7], prog_clock_in, prog_data_in}, 8'h07);
    close_out();
  end
endmodule // pbg_port_tb
